// ===== include/ivq_params.svh
// Offsets, field positions, reset values and sizes of the vector queue.
// Assumes inclusion by the package and by the design file through the include path.
`ifndef IVQ_PARAMS_SVH
`define IVQ_PARAMS_SVH

`define IVQ_FIFO_DEPTH       16
`define IVQ_FIFO_AW          4
`define IVQ_NUM_QUEUES       10
`define IVQ_QUEUE_CFG        4'd8
`define IVQ_RING_AW          4
`define IVQ_SRC_CFG          4'hA
`define IVQ_BIT_HOST_MARKED  18
`define IVQ_BIT_FRAME_DONE   17
`define IVQ_BIT_ERROR        16
`define IVQ_STATUS_MSB       18
`define IVQ_ADDR_CTRL        12'h000
`define IVQ_ADDR_STATUS      12'h004
`define IVQ_ADDR_BASE        12'h008
`define IVQ_ADDR_RING        12'h00C
`define IVQ_ADDR_LEVEL       12'h010
`define IVQ_ADDR_WRPTR0      12'h040
`define IVQ_CTRL_RESET       1'b1
`define IVQ_BASE_RESET       32'h0000_0000
`define IVQ_RING_RESET       4'hF

`endif

// ===== include/ivq_pkg.sv
// Types shared by the vector queue design and its bench.
// Assumes ivq_params.svh is reachable on the include path.
`include "ivq_params.svh"
package ivq_pkg;
	typedef logic [31:0] ivq_word_t;
	typedef logic [18:0] ivq_status_t;
	typedef enum logic [1:0] {
		IVQ_SRC_NONE,
		IVQ_SRC_CFG,
		IVQ_SRC_DMA,
		IVQ_SRC_SERIAL
	} ivq_src_e;
	typedef enum logic [1:0] {
		IVQ_ST_IDLE,
		IVQ_ST_WRITE,
		IVQ_ST_WAIT
	} ivq_state_e;
endpackage : ivq_pkg

// ===== logic/ivq_interrupt_vector_queue.sv
// Interrupt vector queue: builds vectors, buffers them, writes them to host rings.
// Assumes one 20 MHz clock, an AHB-Lite slave port and a simple memory write port.
// Function
// - Sixteen-entry central FIFO of 32-bit vectors.
// - Each vector goes to its source's queue.
// - Per-queue status flag; write one clears.
// - Interrupt line held while any flag pending.
// - Top eight bits encode source type.
// - Configuration vector 1010, zero body, config queue.
// - Bit 1 marks failed action request.
// - Bit 0 marks successful action request.
// - DMA/serial vector: bit31 zero, code selects queue.
// - Bit 18 carries host-marked descriptor flag.
// - Receive frame-done on frame-end branch, reset or hold.
// - Transmit frame-done when frame-end descriptor completes.
// - Transmit hold without frame-end gives error only.
// - Receive error on short hold or reset.
// - Transmit error on empty last non-end descriptor.
// - Serial vector carries channel status bits 18..0.
// - Status byte appended per data byte when enabled.
// - Framing-error bit meaningful only in async mode.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "ivq_params.svh"
module ivq_interrupt_vector_queue (
	input  wire logic                 clk_sys,
	input  wire logic                 reset_n,
	// AHB-Lite slave.
	input  wire logic                 hsel,
	input  wire logic [11:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// Configuration action-request results.
	input  wire logic                 cfg_event,
	input  wire logic                 action_fail_flag,
	input  wire logic                 action_ok_flag,
	// DMA unit descriptor events.
	input  wire logic                 dma_event,
	input  wire logic                 dma_is_tx,
	input  wire logic [1:0]           dma_channel,
	input  wire logic                 dma_host_marked,
	input  wire logic                 dma_frame_end_bit,
	input  wire logic                 dma_branch,
	input  wire logic                 dma_hold,
	input  wire logic                 dma_rx_reset,
	input  wire logic                 dma_short_space,
	input  wire logic                 dma_zero_count,
	// Serial core status copies.
	input  wire logic                 serial_event,
	input  wire logic                 serial_is_tx,
	input  wire logic [1:0]           serial_channel,
	input  wire ivq_pkg::ivq_status_t serial_event_status,
	// Receive status byte append.
	input  wire logic                 rx_status_append,
	input  wire logic                 rx_async_mode,
	input  wire logic                 rx_byte_valid,
	input  wire logic [7:0]           rx_byte,
	input  wire logic                 rx_frame_err,
	input  wire logic [6:0]           rx_other_status,
	output logic      [15:0]          rx_store_word,
	output logic                      rx_store_valid,
	output logic                      rx_store_wide,
	// Shared memory write port.
	output logic      [31:0]          mem_addr,
	output logic      [31:0]          mem_wdata,
	output logic                      mem_write,
	input  wire logic                 mem_ack,
	// Bus interrupt line, active low, open drain.
	output logic                      inta_n_out,
	output logic                      inta_n_oe,
	// Source stall when the FIFO is full.
	output logic                      vector_ready,
	output logic                      vector_dropped
);
	import ivq_pkg::*;

	//****************************************************************
	// Vector formation
	//****************************************************************
	ivq_word_t cfg_vec;
	ivq_word_t dma_vec;
	ivq_word_t ser_vec;
	logic      dma_fi;
	logic      dma_err;

	assign cfg_vec = {`IVQ_SRC_CFG, 26'h0, action_fail_flag, action_ok_flag};

	always_comb begin
		if (dma_is_tx) begin
			dma_fi  = dma_frame_end_bit && (dma_branch || dma_hold);
			dma_err = (dma_hold && !dma_frame_end_bit)
				|| (dma_zero_count && !dma_frame_end_bit);
		end else begin
			dma_fi  = (dma_frame_end_bit && dma_branch) || dma_rx_reset || dma_hold;
			dma_err = (dma_hold && dma_short_space) || dma_rx_reset;
		end
	end

	assign dma_vec = {1'b0, dma_is_tx, dma_channel, 9'h000,
		dma_host_marked, dma_fi, dma_err, 16'h0000};
	// Bit 25 marks the serial core, so its vectors differ from DMA vectors in the top byte.
	assign ser_vec = {1'b0, serial_is_tx, serial_channel, 2'b00, 1'b1, 6'h00,
		serial_event_status};

	//****************************************************************
	// Central FIFO
	//****************************************************************
	ivq_word_t              fifo_mem [`IVQ_FIFO_DEPTH];
	logic [`IVQ_FIFO_AW:0]  wr_ptr_q;
	logic [`IVQ_FIFO_AW:0]  rd_ptr_q;
	logic                   fifo_full;
	logic                   fifo_empty;
	logic                   push;
	logic                   pop;
	ivq_word_t              push_vec;

	assign fifo_full  = (wr_ptr_q[`IVQ_FIFO_AW] != rd_ptr_q[`IVQ_FIFO_AW])
		&& (wr_ptr_q[`IVQ_FIFO_AW-1:0] == rd_ptr_q[`IVQ_FIFO_AW-1:0]);
	assign fifo_empty = (wr_ptr_q == rd_ptr_q);
	assign vector_ready = !fifo_full;

	// Fixed priority, one vector per cycle; sources must hold until vector_ready.
	always_comb begin
		push     = !fifo_full && (cfg_event || dma_event || serial_event);
		push_vec = ser_vec;
		if (cfg_event) begin
			push_vec = cfg_vec;
		end else if (dma_event) begin
			push_vec = dma_vec;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			fifo_mem[wr_ptr_q[`IVQ_FIFO_AW-1:0]] <= push_vec;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			vector_dropped <= 1'b0;
		end else begin
			vector_dropped <= fifo_full && (cfg_event || dma_event || serial_event);
		end
	end

	//****************************************************************
	// Queue writer
	//****************************************************************
	ivq_state_e                       state_q;
	ivq_word_t                        head_vec;
	logic [3:0]                       head_queue;
	logic [3:0]                       cur_queue_q;
	logic [`IVQ_RING_AW-1:0]          ring_ptr_q [`IVQ_NUM_QUEUES];
	logic [`IVQ_RING_AW-1:0]          ring_last_q;
	logic [31:0]                      base_q;
	logic                             enable_q;
	logic [`IVQ_NUM_QUEUES-1:0]       status_q;
	logic [`IVQ_NUM_QUEUES-1:0]       queued_set;

	assign head_vec = fifo_mem[rd_ptr_q[`IVQ_FIFO_AW-1:0]];

	always_comb begin
		if (head_vec[31]) begin
			head_queue = `IVQ_QUEUE_CFG;
		end else begin
			head_queue = {1'b0, head_vec[30:28]};
		end
	end

	assign pop = (state_q == IVQ_ST_WAIT) && mem_ack;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q     <= IVQ_ST_IDLE;
			cur_queue_q <= 4'h0;
			mem_addr    <= 32'h0000_0000;
			mem_wdata   <= 32'h0000_0000;
			mem_write   <= 1'b0;
		end else begin
			case (state_q)
				IVQ_ST_IDLE: begin
					if (!fifo_empty && enable_q) begin
						cur_queue_q <= head_queue;
						mem_wdata   <= head_vec;
						// Each queue owns a 16-word slot; ring_last+1 of them are used.
						mem_addr    <= base_q + {18'h0, head_queue, ring_ptr_q[head_queue],
							2'b00} * 32'(1);
						mem_write   <= 1'b1;
						state_q     <= IVQ_ST_WAIT;
					end
				end
				IVQ_ST_WAIT: begin
					if (mem_ack) begin
						mem_write <= 1'b0;
						state_q   <= IVQ_ST_IDLE;
					end
				end
				default: begin
					state_q <= IVQ_ST_IDLE;
				end
			endcase
		end
	end

	genvar gq;
	generate
		for (gq = 0; gq < `IVQ_NUM_QUEUES; gq++) begin : g_queue
			assign queued_set[gq] = pop && (cur_queue_q == 4'(gq));
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					ring_ptr_q[gq] <= '0;
				end else if (queued_set[gq]) begin
					if (ring_ptr_q[gq] == ring_last_q) begin
						ring_ptr_q[gq] <= '0;
					end else begin
						ring_ptr_q[gq] <= ring_ptr_q[gq] + 1'b1;
					end
				end
			end
		end
	endgenerate

	//****************************************************************
	// Register bus
	//****************************************************************
	logic        wr_pend_q;
	logic        rd_pend_q;
	logic [11:0] addr_q;
	logic        status_clr;
	logic [`IVQ_NUM_QUEUES-1:0] clear_mask;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 12'h000;
		end else begin
			wr_pend_q <= hsel && hready && htrans[1] && hwrite;
			rd_pend_q <= hsel && hready && htrans[1] && !hwrite;
			if (hsel && hready && htrans[1]) begin
				addr_q <= haddr;
			end
		end
	end

	assign status_clr = wr_pend_q && (addr_q == `IVQ_ADDR_STATUS);
	assign clear_mask = status_clr ? hwdata[`IVQ_NUM_QUEUES-1:0] : '0;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			enable_q    <= `IVQ_CTRL_RESET;
			base_q      <= `IVQ_BASE_RESET;
			ring_last_q <= `IVQ_RING_RESET;
		end else if (wr_pend_q) begin
			case (addr_q)
				`IVQ_ADDR_CTRL: enable_q <= hwdata[0];
				`IVQ_ADDR_BASE: base_q <= {hwdata[31:2], 2'b00};
				`IVQ_ADDR_RING: ring_last_q <= hwdata[`IVQ_RING_AW-1:0];
				default: begin
				end
			endcase
		end
	end

	// A new vector in the same cycle as its clear keeps the flag set.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~clear_mask) | queued_set;
		end
	end

	always_comb begin
		hrdata = 32'h0000_0000;
		if (rd_pend_q) begin
			case (addr_q)
				`IVQ_ADDR_CTRL:   hrdata = {31'h0, enable_q};
				`IVQ_ADDR_STATUS: hrdata = {22'h0, status_q};
				`IVQ_ADDR_BASE:   hrdata = base_q;
				`IVQ_ADDR_RING:   hrdata = {28'h0, ring_last_q};
				`IVQ_ADDR_LEVEL:  hrdata = {27'h0, wr_ptr_q - rd_ptr_q};
				default: begin
					if (addr_q[11:6] == 6'h01 && addr_q[5:2] < 4'd10) begin
						hrdata = {28'h0, ring_ptr_q[addr_q[5:2]]};
					end
				end
			endcase
		end
	end

	//****************************************************************
	// Interrupt line
	//****************************************************************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			inta_n_oe <= 1'b0;
		end else begin
			inta_n_oe <= |((status_q & ~clear_mask) | queued_set);
		end
	end
	assign inta_n_out = 1'b0;

	//****************************************************************
	// Receive status append
	//****************************************************************
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rx_store_word  <= 16'h0000;
			rx_store_valid <= 1'b0;
			rx_store_wide  <= 1'b0;
		end else begin
			rx_store_valid <= rx_byte_valid;
			rx_store_wide  <= rx_byte_valid && rx_status_append;
			if (rx_byte_valid) begin
				// Framing error reads as zero outside async mode.
				rx_store_word <= rx_status_append ?
					{rx_frame_err && rx_async_mode, rx_other_status, rx_byte} :
					{8'h00, rx_byte};
			end
		end
	end

endmodule : ivq_interrupt_vector_queue

// ===== verification/ivq_host_model.sv
// Host memory model that answers the vector queue's shared-memory writes.
// Assumes mem_write is held until mem_ack is seen high at a rising edge.
`timescale 1ns/1ps
module ivq_host_model (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic mem_write,
	input  wire logic stall,
	output logic      mem_ack
);
	// ********
	// Answer
	// ********
	logic [1:0] wait_q;
	logic       slow_q;
	// Answers alternate between prompt and slow, so the held write is also seen waiting.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mem_ack <= 1'b0;
			wait_q  <= 2'h0;
			slow_q  <= 1'b0;
		end else if (mem_ack || !mem_write || stall) begin
			mem_ack <= 1'b0;
		end else if (wait_q == 2'h0) begin
			mem_ack <= 1'b1;
			wait_q  <= slow_q ? 2'h0 : 2'h3;
			slow_q  <= !slow_q;
		end else begin
			wait_q <= wait_q - 2'h1;
		end
	end
endmodule : ivq_host_model

// ===== verification/ivq_interrupt_vector_queue_asserts.sv
// Port checker for the interrupt vector queue.
// Assumes the queue base stays zero, so the queue index is mem_addr[9:6].
`timescale 1ns/1ps
module ivq_checker (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        cfg_event,
	input wire logic        dma_event,
	input wire logic        serial_event,
	input wire logic        vector_ready,
	input wire logic        vector_dropped,
	input wire logic        rx_byte_valid,
	input wire logic [7:0]  rx_byte,
	input wire logic        rx_status_append,
	input wire logic [15:0] rx_store_word,
	input wire logic        rx_store_valid,
	input wire logic        rx_store_wide,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic        mem_write,
	input wire logic        mem_ack,
	input wire logic        inta_n_oe
);
	// ********
	// Assertions
	// ********
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	AST_CFG_FORMAT: assert property (mem_write && mem_wdata[31:28] == 4'hA
		|-> mem_wdata[27:2] == 26'h0 && mem_addr[9:6] == 4'h8) else $error("bad config vector");
	AST_QUEUE_SELECT: assert property (mem_write && !mem_wdata[31]
		|-> mem_addr[9:6] == {1'b0, mem_wdata[30:28]}) else $error("wrong queue");
	AST_WRITE_HOLD: assert property (mem_write && !mem_ack
		|=> mem_write && $stable(mem_addr) && $stable(mem_wdata)) else $error("write not held");
	AST_INTA_RAISE: assert property (mem_write && mem_ack |=> inta_n_oe)
		else $error("interrupt line not driven");
	AST_FULL_DROP: assert property ((cfg_event || dma_event || serial_event) && !vector_ready
		|=> vector_dropped) else $error("drop not flagged");
	AST_DROP_CAUSE: assert property (vector_dropped |-> !$past(vector_ready))
		else $error("drop while not full");
	AST_TYPE_BYTE: assert property (mem_write && !mem_wdata[31]
		|-> mem_wdata[27:26] == 2'h0 && mem_wdata[24:19] == 6'h00) else $error("bad type byte");
	AST_APPEND: assert property (rx_byte_valid |=> rx_store_valid
		&& rx_store_wide == $past(rx_status_append) && rx_store_word[7:0] == $past(rx_byte))
		else $error("receive store wrong");
	AST_NO_APPEND: assert property (rx_byte_valid && !rx_status_append
		|=> rx_store_word[15:8] == 8'h0) else $error("status stored unasked");
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not okay");
endmodule : ivq_checker
bind ivq_interrupt_vector_queue ivq_checker u_chk (.*);

// ===== verification/ivq_interrupt_vector_queue_bench.sv
// Self-checking bench of the interrupt vector queue.
// Assumes the host model answers memory writes; queue base stays zero.
`timescale 1ns/1ps
module ivq_interrupt_vector_queue_bench;
	import ivq_pkg::*;
	typedef struct packed {
		logic [1:0]  k;
		logic [11:0] in;
		logic [18:0] st;
		ivq_word_t   v;
	} ivq_row_s;
	// ********
	// Signals
	// ********
	logic        clk_sys, reset_n, hsel, hwrite, cfg_event, dma_event, serial_event, stall;
	logic        rx_status_append, rx_async_mode, rx_byte_valid, rx_frame_err, hreadyout;
	logic        hresp, rx_store_valid, rx_store_wide, mem_write, mem_ack, inta_n_out;
	logic        inta_n_oe, vector_ready, vector_dropped;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [6:0]  rx_other_status;
	logic [7:0]  rx_byte;
	logic [11:0] haddr, ev;
	logic [15:0] rx_store_word;
	ivq_word_t   hwdata, hrdata, mem_addr, mem_wdata, rd;
	ivq_status_t serial_event_status;
	logic [3:0]  lq, ptr [10];
	int          fail_count, n_checks, i;
	wire logic   hready, dma_is_tx, dma_host_marked, dma_frame_end_bit, dma_branch, dma_hold;
	wire logic   dma_rx_reset, dma_short_space, dma_zero_count, serial_is_tx;
	wire logic   action_fail_flag, action_ok_flag;
	wire logic [1:0] dma_channel, serial_channel;
	ivq_row_s    rows [13] = '{'{2'd0, 12'h001, 19'h0, 32'hA0000002},
		'{2'd0, 12'h002, 19'h0, 32'hA0000001}, '{2'd0, 12'h000, 19'h0, 32'hA0000000},
		'{2'd1, 12'h0C0, 19'h0, 32'h00020000}, '{2'd1, 12'h508, 19'h0, 32'h10030000},
		'{2'd1, 12'h210, 19'h0, 32'h20030000}, '{2'd1, 12'h0B8, 19'h0, 32'h30040000},
		'{2'd1, 12'h0C4, 19'h0, 32'h40020000}, '{2'd1, 12'h14C, 19'h0, 32'h50020000},
		'{2'd1, 12'h114, 19'h0, 32'h60010000}, '{2'd1, 12'h89C, 19'h0, 32'h70010000},
		'{2'd2, 12'h008, 19'h5A5A5, 32'h1205A5A5}, '{2'd2, 12'h01C, 19'h2C3C3, 32'h7202C3C3}};
	assign hready = hreadyout;
	assign {dma_zero_count, dma_short_space, dma_rx_reset, dma_hold, dma_branch, dma_frame_end_bit,
		dma_host_marked, dma_channel, dma_is_tx, action_ok_flag, action_fail_flag} = ev;
	assign {serial_channel, serial_is_tx} = ev[4:2];
	ivq_interrupt_vector_queue u_dut (.*);
	ivq_host_model u_host (.*);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// ********
	// Tasks
	// ********
	task automatic print_verdict;
		if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic chk(input string what, input ivq_word_t e, input ivq_word_t s);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	// Waits on 0: bus ready, 1: vector taken, 2: memory write answered.
	task automatic wait_on(input int s);
		for (int j = 0; j < 200; j++) begin
			@(posedge clk_sys);
			if ((s == 0 && hready === 1'b1) || (s == 1 && vector_ready === 1'b1)
				|| (s == 2 && mem_write === 1'b1 && mem_ack === 1'b1)) return;
		end
		fail_count++;
		print_verdict();
	endtask : wait_on
	task automatic ahb(input logic w, input logic [11:0] a, input ivq_word_t d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_on(0);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_on(0);
		rd = hrdata;
	endtask : ahb
	task automatic push(input ivq_row_s r);
		@(posedge clk_sys);
		ev <= r.in;
		serial_event_status <= r.st;
		{cfg_event, dma_event, serial_event} <= {r.k == 2'd0, r.k == 2'd1, r.k == 2'd2};
		wait_on(1);
		{cfg_event, dma_event, serial_event} <= 3'h0;
	endtask : push
	task automatic expect_write(input ivq_word_t v, input ivq_word_t m);
		lq = v[31] ? 4'h8 : {1'b0, v[30:28]};
		wait_on(2);
		chk("mem_wdata", v & m, mem_wdata & m);
		chk("mem_addr", 32'({lq, ptr[lq], 2'h0}), mem_addr);
		ptr[lq] = ptr[lq] + 4'h1;
	endtask : expect_write
	// ********
	// Sequence
	// ********
	initial begin
		{reset_n, hsel, hwrite, cfg_event, dma_event, serial_event, stall} = '0;
		{rx_status_append, rx_async_mode, rx_byte_valid, rx_frame_err} = '0;
		{htrans, haddr, hwdata, ev, serial_event_status, rx_byte, rx_other_status} = '0;
		hsize = 3'h2;
		foreach (ptr[j]) ptr[j] = 4'h0;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		ahb(1'b0, 12'h000, 0);
		chk("ctrl", 32'h1, rd);
		ahb(1'b0, 12'h00C, 0);
		chk("ring", 32'hF, rd);
		ahb(1'b1, 12'h100, 32'hFFFFFFFF);
		ahb(1'b0, 12'h100, 0);
		chk("unmapped", 32'h0, rd);
		chk("inta idle", 32'h0, 32'(inta_n_oe));
		foreach (rows[j]) begin
			push(rows[j]);
			expect_write(rows[j].v, 32'hFFFFFFFF);
			ahb(1'b1, 12'h004, 0);
			ahb(1'b0, 12'h004, 0);
			chk("status", 32'h1 << lq, rd);
			chk("inta", 32'h1, 32'(inta_n_oe));
			chk("inta line", 32'h0, 32'(inta_n_out));
			ahb(1'b1, 12'h004, 32'h1 << lq);
			ahb(1'b0, 12'h004, 0);
			chk("status clear", 32'h0, rd);
			chk("inta clear", 32'h0, 32'(inta_n_oe));
		end
		for (i = 0; i < 14; i++) begin
			push(rows[2]);
			expect_write(32'hA0000000, 32'hFFFFFFFF);
		end
		stall <= 1'b1;
		for (i = 0; i < 16; i++) push(rows[2]);
		@(posedge clk_sys);
		chk("vector_ready", 32'h0, 32'(vector_ready));
		cfg_event <= 1'b1;
		@(posedge clk_sys);
		cfg_event <= 1'b0;
		@(posedge clk_sys);
		chk("vector_dropped", 32'h1, 32'(vector_dropped));
		ahb(1'b0, 12'h010, 0);
		chk("level", 32'd16, rd);
		stall <= 1'b0;
		for (i = 0; i < 16; i++) expect_write(32'hA0000000, 32'hFFFFFFFF);
		for (i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			{rx_status_append, rx_async_mode, rx_frame_err, rx_byte_valid} <= {i[1:0], 2'h3};
			rx_byte <= 8'h3C + 8'(i);
			rx_other_status <= 7'h55;
			@(posedge clk_sys);
			rx_byte_valid <= 1'b0;
			@(posedge clk_sys);
			chk("rx byte", 32'(8'h3C + 8'(i)), 32'(rx_store_word[7:0]));
			chk("rx wide", 32'(i[1]), 32'(rx_store_wide));
			chk("rx status", 32'(i[1] ? {i[0], 7'h55} : 8'h00), 32'(rx_store_word[15:8]));
		end
		print_verdict();
	end
endmodule : ivq_interrupt_vector_queue_bench
